// ==== rtl/bsr_pkg.sv ====
// package: constants, types and helpers of the bridge converter readout
package bsr_pkg;

	// ==========================================================
	// clock and conversion timing
	localparam int REF_CLK_HZ       = 25_000_000;
	localparam int RATE_SLOW_SPS    = 10;
	localparam int RATE_FAST_SPS    = 40;
	localparam int CONV_SLOW_CYCLES = REF_CLK_HZ / RATE_SLOW_SPS;
	localparam int CONV_FAST_CYCLES = REF_CLK_HZ / RATE_FAST_SPS;

	// ==========================================================
	// power-down and settling
	localparam int PD_HIGH_US     = 60;
	localparam int PD_CYCLES      = (PD_HIGH_US * (REF_CLK_HZ / 1_000_000));
	localparam int PD_W           = $clog2(PD_CYCLES + 1);
	localparam int SETTLE_SLOW_MS = 400;
	localparam int SETTLE_FAST_MS = 100;
	localparam int SETTLE_CONV    = (SETTLE_SLOW_MS * RATE_SLOW_SPS) / 1000;
	localparam int SETTLE_W       = $clog2(SETTLE_CONV + 1);

	// ==========================================================
	// data format
	localparam int DATA_W                = 24;
	localparam int RAW_W                 = 28;
	localparam logic [DATA_W-1:0] CODE_MIN = 24'h80_0000;
	localparam logic [DATA_W-1:0] CODE_MAX = 24'h7F_FFFF;

	// ==========================================================
	// pulse counts per readout
	localparam int FRM_W                      = 5;
	localparam logic [FRM_W-1:0] PULSES_DIFF_SLOW = 5'h19;
	localparam logic [FRM_W-1:0] PULSES_AUX_FAST  = 5'h1A;
	localparam logic [FRM_W-1:0] PULSES_DIFF_FAST = 5'h1B;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		SEL_DIFF_SLOW,
		SEL_AUX_FAST,
		SEL_DIFF_FAST
	} bsr_sel_t;

	typedef enum logic {
		ST_RUN,
		ST_DOWN
	} bsr_state_t;

	localparam bsr_sel_t SEL_RESET = SEL_DIFF_SLOW;

	// ==========================================================
	// helpers
	function automatic bsr_sel_t pulses_to_sel(input logic [FRM_W-1:0] n);
		bsr_sel_t s;
		s = SEL_DIFF_SLOW;
		if (n == PULSES_AUX_FAST) begin
			s = SEL_AUX_FAST;
		end else if (n == PULSES_DIFF_FAST) begin
			s = SEL_DIFF_FAST;
		end
		return s;
	endfunction : pulses_to_sel

	function automatic logic sel_is_fast(input bsr_sel_t s);
		return (s != SEL_DIFF_SLOW);
	endfunction : sel_is_fast

	function automatic logic [DATA_W-1:0] clamp_code(input logic [RAW_W-1:0] raw);
		logic [RAW_W-DATA_W:0] top;
		top = raw[RAW_W-1:DATA_W-1];
		if ((top == '0) || (top == '1)) begin
			return raw[DATA_W-1:0];
		end
		return raw[RAW_W-1] ? CODE_MIN : CODE_MAX;
	endfunction : clamp_code

endpackage : bsr_pkg

// ==== rtl/bsr_link_if.sv ====
// interface: result hand-over between the oscillator side and the shift clock side
`timescale 1ns/1ps
interface bsr_link_if #(parameter int DATA_W = 24);
	logic              ready;
	logic [DATA_W-1:0] word;
	logic              active;
	logic              shift_bit;

	modport ctrl (output ready, output word, input active, input shift_bit);
	modport link (input ready, input word, output active, output shift_bit);
endinterface : bsr_link_if

// ==== rtl/bsr_sync.sv ====
// module: two flip-flop level synchroniser
`timescale 1ns/1ps
module bsr_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// level in and out
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule : bsr_sync

// ==== rtl/bsr_shift_link.sv ====
// module: result shifter clocked by the host shift clock
`timescale 1ns/1ps
module bsr_shift_link
	import bsr_pkg::*;
(
	// host shift clock
	input  wire logic shift_clk,
	// hand-over with the oscillator side
	bsr_link_if.link  lk
);

	logic [FRM_W-1:0] cnt_reg;
	logic             clr;
	logic             more;

	// held clear whenever no result is offered
	assign clr  = ~lk.ready;
	assign more = (cnt_reg < FRM_W'(DATA_W));

	always_ff @(posedge shift_clk or posedge clr) begin
		if (clr) begin
			cnt_reg      <= '0;
			lk.active    <= 1'b0;
			lk.shift_bit <= 1'b1;
		end else begin
			lk.active <= 1'b1;
			if (more) begin
				cnt_reg      <= cnt_reg + 1'b1;
				lk.shift_bit <= lk.word[DATA_W-1-cnt_reg]; // see R7
			end else begin
				lk.shift_bit <= 1'b1; // see R8
			end
		end
	end

endmodule : bsr_shift_link

// ==== rtl/bsr_adc_readout.sv ====
// module: digital core of the bridge converter with its serial readout
//
// Overview of operation
// R1: conversion timing comes from internal oscillator only
// R2: result rate is 10 or 40 per second
// R3: each result is 24-bit two's complement
// R4: out-of-range input clamps to min or max code
// R5: data line high while no result ready
// R6: data line low announces a new result
// R7: each shift pulse presents next bit, MSB first
// R8: pulse after last bit drives data line high
// R9: 25, 26, 27 pulses select input and rate
// R10: host gives 25 to 27 pulses per period
// R11: shift clock low keeps normal converting operation
// R12: clock high over 60 us enters power-down
// R13: wake restores last input and rate selection
// R14: host waits period end before requesting power-down
// R15: power-on reset initialises logic without host action
// R16: results dropped while settling after reset or change
// R17: new selection applies to the following conversion
// R18: host samples after each rise, short high phases
`timescale 1ns/1ps
module bsr_adc_readout
	import bsr_pkg::*;
#(
	parameter int SLOW_CYCLES = CONV_SLOW_CYCLES,
	parameter int FAST_CYCLES = CONV_FAST_CYCLES
) (
	// internal oscillator and power-on reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// serial pins
	input  wire logic             pwrdn_shift_clock,
	output logic                  dout,
	// analog front end
	input  wire logic [RAW_W-1:0] conv_raw,
	output logic                  conv_start,
	output logic                  sel_aux,
	output logic                  rate_fast,
	// status
	output logic                  powered_down,
	output logic                  serial_err
);

	// ==========================================================
	// local widths and limits
	localparam int TMR_W = $clog2(SLOW_CYCLES + 1);
	localparam logic [TMR_W-1:0]    SLOW_LAST = TMR_W'(SLOW_CYCLES - 1);
	localparam logic [TMR_W-1:0]    FAST_LAST = TMR_W'(FAST_CYCLES - 1);
	localparam logic [PD_W-1:0]     PD_LIMIT  = PD_W'(PD_CYCLES);
	localparam logic [SETTLE_W-1:0] SETTLE_V  = SETTLE_W'(SETTLE_CONV);
	localparam logic [FRM_W-1:0]    FRM_LAST  = FRM_W'(DATA_W);
	localparam logic [FRM_W-1:0]    FRM_FULL  = '1;

	// ==========================================================
	// signals
	logic                sck_sync;
	logic                sck_d_reg;
	logic                sck_rise;
	logic [PD_W-1:0]     hi_cnt_reg;
	logic [PD_W-1:0]     hi_cnt_next;
	bsr_state_t          state_reg;
	bsr_state_t          state_next;
	logic [TMR_W-1:0]    tmr_reg;
	logic [TMR_W-1:0]    tmr_next;
	logic [TMR_W-1:0]    period_last;
	logic [FRM_W-1:0]    frm_cnt_reg;
	logic [FRM_W-1:0]    frm_cnt_next;
	bsr_sel_t            sel_reg;
	bsr_sel_t            sel_next;
	bsr_sel_t            sel_pick;
	logic [SETTLE_W-1:0] settle_reg;
	logic [SETTLE_W-1:0] settle_next;
	logic                ready_reg;
	logic                ready_next;
	logic [DATA_W-1:0]   word_reg;
	logic [DATA_W-1:0]   word_next;
	logic                err_reg;
	logic                err_next;
	logic                conv_start_reg;
	logic                running;
	logic                pd_enter;
	logic                wake;
	logic                conv_done;
	logic                read_done;
	logic                cnt_ok;
	logic                sel_change;
	logic                settled;
	logic                load;
	logic                last_rise;

	bsr_link_if #(.DATA_W(DATA_W)) lk ();

	// ==========================================================
	// shift clock pin seen from the oscillator domain
	bsr_sync #(
		.WIDTH (1)
	) u_sck_sync (
		.clk (ref_clk),
		.rst (rst),
		.d   (pwrdn_shift_clock),
		.q   (sck_sync)
	);

	assign sck_rise = sck_sync & ~sck_d_reg;

	// ==========================================================
	// power-down detection
	assign running  = (state_reg == ST_RUN);
	assign pd_enter = running && (hi_cnt_reg == PD_LIMIT); // see R12
	assign wake     = (state_reg == ST_DOWN) && !sck_sync; // see R11

	assign hi_cnt_next = !sck_sync ? '0 :
		(hi_cnt_reg == PD_LIMIT) ? hi_cnt_reg : hi_cnt_reg + 1'b1;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN: begin
				if (pd_enter) begin
					state_next = ST_DOWN; // see R12
				end
			end
			ST_DOWN: begin
				if (!sck_sync) begin
					state_next = ST_RUN; // see R13
				end
			end
		endcase
	end

	// ==========================================================
	// conversion period from the oscillator
	assign period_last = sel_is_fast(sel_reg) ? FAST_LAST : SLOW_LAST; // see R2
	assign conv_done   = running && (tmr_reg == period_last); // see R1
	assign tmr_next    = (!running || conv_done) ? '0 : tmr_reg + 1'b1;

	// ==========================================================
	// readout pulse counting and selection
	assign read_done  = !ready_reg && (frm_cnt_reg != '0);
	assign cnt_ok     = (frm_cnt_reg >= PULSES_DIFF_SLOW) &&
		(frm_cnt_reg <= PULSES_DIFF_FAST); // see R10
	assign sel_pick   = pulses_to_sel(frm_cnt_reg); // see R9
	assign sel_change = conv_done && read_done && cnt_ok &&
		(sel_pick != sel_reg); // see R17
	assign sel_next   = sel_change ? sel_pick : sel_reg; // see R13
	assign last_rise  = running && sck_rise && ready_reg &&
		(frm_cnt_reg == FRM_LAST); // see R8

	always_comb begin
		frm_cnt_next = frm_cnt_reg;
		if (!running || load || (conv_done && read_done)) begin
			frm_cnt_next = '0;
		end else if (sck_rise && (frm_cnt_reg != FRM_FULL)) begin
			frm_cnt_next = frm_cnt_reg + 1'b1;
		end
	end

	always_comb begin
		err_next = err_reg;
		if (conv_done && read_done) begin
			err_next = !cnt_ok; // see R10
		end
	end

	// ==========================================================
	// settling and result hand-over
	assign settled = (settle_reg == '0);
	assign load    = conv_done && settled && !sel_change && !ready_reg; // see R16

	always_comb begin
		settle_next = settle_reg;
		if (wake || sel_change) begin
			settle_next = SETTLE_V; // see R16
		end else if (conv_done && !settled) begin
			settle_next = settle_reg - 1'b1;
		end
	end

	assign word_next = load ? clamp_code(conv_raw) : word_reg; // see R4

	always_comb begin
		ready_next = ready_reg;
		if (load) begin
			ready_next = 1'b1; // see R6
		end else if (last_rise || !running) begin
			ready_next = 1'b0; // see R8
		end
	end

	// ==========================================================
	// registers, initialised by the power-on reset
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin // see R15
			sck_d_reg <= 1'b0;
		end else begin
			sck_d_reg <= sck_sync;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hi_cnt_reg <= '0;
		end else begin
			hi_cnt_reg <= hi_cnt_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tmr_reg <= '0;
		end else begin
			tmr_reg <= tmr_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			frm_cnt_reg <= '0;
		end else begin
			frm_cnt_reg <= frm_cnt_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sel_reg <= SEL_RESET;
		end else begin
			sel_reg <= sel_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			settle_reg <= SETTLE_V;
		end else begin
			settle_reg <= settle_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= ready_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			word_reg <= '0;
		end else begin
			word_reg <= word_next; // see R3
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			err_reg <= 1'b0;
		end else begin
			err_reg <= err_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			conv_start_reg <= 1'b0;
		end else begin
			conv_start_reg <= conv_done || wake;
		end
	end

	// ==========================================================
	// shift clock side
	assign lk.ready = ready_reg;
	assign lk.word  = word_reg;

	bsr_shift_link u_link (
		.shift_clk (pwrdn_shift_clock),
		.lk        (lk.link)
	);

	// ==========================================================
	// outputs
	assign dout         = lk.active ? lk.shift_bit : ~ready_reg; // see R5
	assign conv_start   = conv_start_reg;
	assign sel_aux      = (sel_reg == SEL_AUX_FAST);
	assign rate_fast    = sel_is_fast(sel_reg);
	assign powered_down = (state_reg == ST_DOWN);
	assign serial_err   = err_reg;

endmodule : bsr_adc_readout

// ==== tb/bsr_adc_readout_sva.sv ====
// checker: port assertions of the bridge converter readout
`timescale 1ns/1ps
module bsr_adc_readout_sva
	import bsr_pkg::*;
#(
	parameter int SLOW_CYCLES = CONV_SLOW_CYCLES,
	parameter int FAST_CYCLES = CONV_FAST_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// pins and status
	input wire logic pwrdn_shift_clock,
	input wire logic dout,
	input wire logic conv_start,
	input wire logic sel_aux,
	input wire logic rate_fast,
	input wire logic powered_down,
	input wire logic serial_err
);
	logic [15:0] hi_cnt;
	logic [31:0] gap_cnt;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// helper counters
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hi_cnt  <= 16'h0000;
			gap_cnt <= 32'hFFFF_FFFF;
		end else begin
			hi_cnt  <= pwrdn_shift_clock ? hi_cnt + {15'h0000, hi_cnt != 16'hFFFF} : 16'h0000;
			gap_cnt <= conv_start ? 32'h0000_0001 : gap_cnt + {31'h0000_0000, ~&gap_cnt};
		end
	end
	// ==========================================================
	// assertions
	chk_reset_idle: assert property ($fell(rst) |-> dout && !powered_down && !serial_err
		&& !sel_aux && !rate_fast) else $error("state after reset wrong");
	chk_pd_enter: assert property (hi_cnt == PD_CYCLES + 6 |-> powered_down)
		else $error("no power-down after long high");
	chk_pd_early: assert property ($rose(powered_down) |-> hi_cnt >= PD_CYCLES)
		else $error("power-down too early");
	chk_pd_dout: assert property (powered_down && $past(powered_down) |-> dout)
		else $error("data low in power-down");
	chk_wake_fast: assert property ((powered_down && !pwrdn_shift_clock) [*5] |=> !powered_down)
		else $error("no wake after pin low");
	chk_start_one: assert property (conv_start |=> !conv_start)
		else $error("start pulse too long");
	chk_start_gap: assert property (conv_start |-> gap_cnt >= FAST_CYCLES - 1)
		else $error("periods too close");
	chk_sel_code: assert property (!(sel_aux && !rate_fast))
		else $error("aux input at slow rate");
	chk_sel_moment: assert property ($changed({sel_aux, rate_fast}) |-> ##[0:1] conv_start)
		else $error("selection changed mid period");
	chk_err_moment: assert property ($changed(serial_err) |-> ##[0:1] conv_start)
		else $error("error flag changed mid period");
	cov_read: cover property ($fell(dout));
	cov_down: cover property ($rose(powered_down));
	cov_aux: cover property ($rose(sel_aux));
	cov_err: cover property ($rose(serial_err));
endmodule : bsr_adc_readout_sva

// ==== tb/bsr_host_model.sv ====
// host model: drives the shift clock pin and reads serial data
`timescale 1ns/1ps
module bsr_host_model (
	// serial pins
	output logic      pwrdn_shift_clock,
	input  wire logic dout
);
	logic lclk;
	logic run;
	initial begin
		run = 1'b0;
		lclk = 1'b0;
		pwrdn_shift_clock = 1'b0;
		#7;
		forever #40 lclk = run ? ~lclk : 1'b0;
	end
	// ==========================================================
	// one readout of n pulses; pin stays low while data is high
	task automatic read(input int n, output logic [23:0] w, output logic end_hi);
		int t;
		t = 0;
		w = 24'h00_0000;
		end_hi = 1'b0;
		while (dout !== 1'b0 && t < 200000) begin
			#40;
			t++;
		end
		run = 1'b1;
		repeat (2) @(posedge lclk);
		for (int i = 1; i <= n; i++) begin
			pwrdn_shift_clock = 1'b1;
			repeat (2) @(posedge lclk);
			if (i <= 24) w = {w[22:0], dout};
			if (i == 25) end_hi = dout;
			pwrdn_shift_clock = 1'b0;
			repeat (2) @(posedge lclk);
		end
		run = 1'b0;
	endtask : read
	// level hold for power-down, called after a period end
	task automatic park(input logic v);
		pwrdn_shift_clock = v;
	endtask : park
endmodule : bsr_host_model

// ==== tb/bsr_adc_readout_tb.sv ====
// testbench: bridge converter readout
`timescale 1ns/1ps
module bsr_adc_readout_tb;
	import bsr_pkg::*;
	localparam int SLOW = 1000;
	localparam int FAST = 400;
	logic ref_clk, rst, pin, dout, conv_start, sel_aux, rate_fast, powered_down, serial_err;
	logic [RAW_W-1:0] conv_raw;
	logic [DATA_W-1:0] w;
	logic e;
	int err_total, check_count, c;
	bsr_adc_readout #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) u_bsr_adc_readout (
		.ref_clk(ref_clk), .rst(rst), .pwrdn_shift_clock(pin), .dout(dout),
		.conv_raw(conv_raw), .conv_start(conv_start), .sel_aux(sel_aux),
		.rate_fast(rate_fast), .powered_down(powered_down), .serial_err(serial_err));
	bsr_host_model u_bsr_host_model (.pwrdn_shift_clock(pin), .dout(dout));
	always #20 ref_clk = ~ref_clk;
	// ==========================================================
	// helpers
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic results();
		if (err_total == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	task automatic wait_start();
		c = 0;
		do begin
			@(negedge ref_clk);
			c++;
		end while (conv_start !== 1'b1 && c < 4 * SLOW);
	endtask : wait_start
	// ==========================================================
	// scenarios
	task automatic t_data();
		logic [RAW_W-1:0] raw [4] = '{28'h012_3456, 28'hFF8_0001, 28'h080_0000, 28'hF7F_FFFF};
		logic [DATA_W-1:0] exp [4] = '{24'h12_3456, 24'hF8_0001, 24'h7F_FFFF, 24'h80_0000};
		for (int k = 0; k < 4; k++) begin
			@(negedge ref_clk);
			conv_raw = raw[k];
			u_bsr_host_model.read(25, w, e);
			u_bsr_host_model.read(25, w, e);
			check("word", w, exp[k]);
			check("end high", e, 1'b1);
		end
	endtask : t_data
	task automatic t_select();
		int p [3] = '{26, 27, 25};
		for (int k = 0; k < 3; k++) begin
			u_bsr_host_model.read(p[k], w, e);
			wait_start();
			check("aux", sel_aux, p[k] == 26);
			check("fast", rate_fast, p[k] != 25);
			wait_start();
			wait_start();
			check("period", c, (p[k] != 25) ? FAST : SLOW);
		end
	endtask : t_select
	task automatic t_error();
		u_bsr_host_model.read(28, w, e);
		wait_start();
		check("err set", serial_err, 1'b1);
		u_bsr_host_model.read(25, w, e);
		wait_start();
		check("err clear", serial_err, 1'b0);
	endtask : t_error
	task automatic t_pd();
		u_bsr_host_model.read(27, w, e);
		wait_start();
		u_bsr_host_model.park(1'b1);
		repeat (1750) @(negedge ref_clk);
		check("down", powered_down, 1'b1);
		check("dout down", dout, 1'b1);
		u_bsr_host_model.park(1'b0);
		repeat (10) @(negedge ref_clk);
		check("woke", powered_down, 1'b0);
		check("kept", {sel_aux, rate_fast}, 2'b01);
		u_bsr_host_model.read(25, w, e);
		check("read after wake", e, 1'b1);
	endtask : t_pd
	// ==========================================================
	// main sequence and watchdog
	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		conv_raw = 28'h000_0000;
		err_total = 0;
		check_count = 0;
		repeat (3) @(negedge ref_clk);
		rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		check("reset", {dout, sel_aux, rate_fast, powered_down, serial_err}, 5'h10);
		t_data();
		t_select();
		t_error();
		t_pd();
		results();
	end
	initial begin
		#4_000_000;
		err_total++;
		results();
	end
endmodule : bsr_adc_readout_tb
bind bsr_adc_readout bsr_adc_readout_sva #(.SLOW_CYCLES(SLOW_CYCLES), .FAST_CYCLES(FAST_CYCLES))
	u_bsr_adc_readout_sva (.ref_clk(ref_clk), .rst(rst), .pwrdn_shift_clock(pwrdn_shift_clock),
	.dout(dout), .conv_start(conv_start), .sel_aux(sel_aux), .rate_fast(rate_fast),
	.powered_down(powered_down), .serial_err(serial_err));
